// [mie_pkg.sv]
// Shared constants and types for the instruction execution subset.
// Assumes a single 125 MHz system clock and an APB register port.
`default_nettype none
package mie_pkg;

  localparam int          DATA_W    = 8;
  localparam int          RAM_AW    = 8;
  localparam int          ROM_W     = 16;
  localparam int          PAGE_W    = 5;
  localparam int          ROM_AW    = PAGE_W + DATA_W;
  localparam int          APB_AW    = 8;
  localparam int          APB_DW    = 32;
  localparam int          STATUS_W  = 6;

  localparam logic [PAGE_W-1:0] LAST_PAGE = 5'h1F;
  localparam logic [DATA_W-1:0] ALL_ONES  = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE  = 8'h01;

  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_ACC           = 8'h00;
  localparam logic [APB_AW-1:0] REG_STATUS        = 8'h04;
  localparam logic [APB_AW-1:0] REG_TABLE_POINTER = 8'h08;
  localparam logic [APB_AW-1:0] REG_TABLE_HIGH    = 8'h0C;
  localparam logic [APB_AW-1:0] REG_STATE         = 8'h10;

  // Reset values
  localparam logic [DATA_W-1:0]   ACC_RST           = 8'h00;
  localparam logic [STATUS_W-1:0] STATUS_RST        = 6'h00;
  localparam logic [DATA_W-1:0]   TABLE_POINTER_RST = 8'h00;
  localparam logic [DATA_W-1:0]   TABLE_HIGH_RST    = 8'h00;

  typedef enum logic [3:0] {
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_INC_MEM_SKIP_ZERO,
    OP_INC_TO_ACC_SKIP_ZERO,
    OP_SKIP_BIT_NONZERO,
    OP_SKIP_BIT_ZERO,
    OP_SKIP_IF_ZERO,
    OP_LOAD_ACC_SKIP_ZERO,
    OP_SUBTRACT_TO_ACC,
    OP_SUBTRACT_TO_MEMORY,
    OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_TO_ACC,
    OP_XOR_TO_MEMORY,
    OP_XOR_TO_ACC,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE
  } mie_op_type;

  typedef enum {ST_IDLE, ST_WAIT, ST_EXEC, ST_DUMMY} mie_state_type;

  typedef struct packed {
    logic               valid;
    mie_op_type         op;
    logic [RAM_AW-1:0]  addr;
    logic [2:0]         bit_sel;
  } mie_instr_type;

  typedef struct packed {
    logic               rd_en;
    logic               wr_en;
    logic [RAM_AW-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } mie_ram_req_type;

  // Bit 0 is carry, bit 5 is timeout
  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } mie_flags_type;

endpackage

`default_nettype wire

// [mie_exec.sv]
// Executes the skip, set, subtract, swap, exclusive-OR and table-read
// instructions of an 8-bit core. Assumes synchronous RAM and ROM with
// one cycle of read latency, on the same clock, and an APB master.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none

module mie_exec (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire mie_pkg::mie_instr_type        instr,
  output logic                               instr_ready,
  input  wire logic [mie_pkg::PAGE_W-1:0]    cur_page,
  output mie_pkg::mie_ram_req_type           ram_req,
  input  wire logic [mie_pkg::DATA_W-1:0]    ram_rdata,
  output logic                               rom_rd_en,
  output logic [mie_pkg::ROM_AW-1:0]         rom_addr,
  input  wire logic [mie_pkg::ROM_W-1:0]     rom_rdata,
  output logic                               exec_done,
  output logic                               skip_next,
  output logic [mie_pkg::DATA_W-1:0]         acc,
  output mie_pkg::mie_flags_type             flags,
  output logic [mie_pkg::DATA_W-1:0]         table_high_latch,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [mie_pkg::APB_AW-1:0]    paddr,
  input  wire logic [mie_pkg::APB_DW-1:0]    pwdata,
  output logic [mie_pkg::APB_DW-1:0]         prdata,
  output logic                               pready,
  output logic                               pslverr
);
  import mie_pkg::*;

  mie_state_type       state;
  mie_op_type          op_q;
  logic [2:0]          bit_q;
  logic [DATA_W-1:0]   table_pointer;
  logic                last_skip;
  logic                take;
  logic                exec_fire;
  logic                apb_fire;
  logic                apb_wr;
  logic                addr_ok;
  logic                sel_bit;
  logic [DATA_W:0]     sub_sum;
  logic [4:0]          sub_low;
  logic [DATA_W-1:0]   inc_val;
  logic [DATA_W-1:0]   next_acc;
  mie_flags_type       next_flags;
  logic                next_wr;
  logic [DATA_W-1:0]   next_wdata;
  logic                next_skip;
  logic [DATA_W-1:0]   next_prdata;

  assign take      = instr_ready && instr.valid;
  assign exec_fire = (state == ST_EXEC);
  assign apb_fire  = psel && penable && pready;
  assign apb_wr    = apb_fire && pwrite;
  assign sel_bit   = ram_rdata[bit_q];
  assign inc_val   = ram_rdata + ONE_BYTE;
  // Two's complement subtraction: acc + ~m + 1
  assign sub_sum   = {1'b0, acc} + {1'b0, ~ram_rdata} + {{DATA_W{1'b0}}, 1'b1};
  assign sub_low   = {1'b0, acc[3:0]} + {1'b0, ~ram_rdata[3:0]} + 5'h01;

  always_comb begin
    next_acc   = acc;
    next_flags = flags;
    next_wr    = 1'b0;
    next_wdata = ram_rdata;
    next_skip  = 1'b0;
    case (op_q)
      OP_SET_BYTE: begin
        next_wr    = 1'b1;
        next_wdata = ALL_ONES;
      end
      OP_SET_BIT: begin
        next_wr             = 1'b1;
        next_wdata[bit_q]   = 1'b1;
      end
      OP_INC_MEM_SKIP_ZERO: begin
        next_wr    = 1'b1;
        next_wdata = inc_val;
        next_skip  = (inc_val == ZERO_BYTE);
      end
      OP_INC_TO_ACC_SKIP_ZERO: begin
        next_acc  = inc_val;
        next_skip = (inc_val == ZERO_BYTE);
      end
      OP_SKIP_BIT_NONZERO: begin
        next_skip = sel_bit;
      end
      OP_SKIP_BIT_ZERO: begin
        next_skip = !sel_bit;
      end
      OP_SKIP_IF_ZERO: begin
        next_skip = (ram_rdata == ZERO_BYTE);
      end
      OP_LOAD_ACC_SKIP_ZERO: begin
        next_acc  = ram_rdata;
        next_skip = (ram_rdata == ZERO_BYTE);
      end
      OP_SUBTRACT_TO_ACC, OP_SUBTRACT_TO_MEMORY: begin
        next_flags.carry_flag     = sub_sum[DATA_W];
        next_flags.aux_carry_flag = sub_low[4];
        next_flags.zero_flag      = (sub_sum[DATA_W-1:0] == ZERO_BYTE);
        next_flags.overflow_flag  = (acc[7] != ram_rdata[7]) && (sub_sum[7] != acc[7]);
        if (op_q == OP_SUBTRACT_TO_ACC) begin
          next_acc = sub_sum[DATA_W-1:0];
        end else begin
          next_wr    = 1'b1;
          next_wdata = sub_sum[DATA_W-1:0];
        end
      end
      OP_NIBBLE_EXCHANGE: begin
        next_wr    = 1'b1;
        next_wdata = {ram_rdata[3:0], ram_rdata[7:4]};
      end
      OP_NIBBLE_EXCHANGE_TO_ACC: begin
        next_acc = {ram_rdata[3:0], ram_rdata[7:4]};
      end
      OP_XOR_TO_MEMORY: begin
        next_wr              = 1'b1;
        next_wdata           = acc ^ ram_rdata;
        next_flags.zero_flag = ((acc ^ ram_rdata) == ZERO_BYTE);
      end
      OP_XOR_TO_ACC: begin
        next_acc             = acc ^ ram_rdata;
        next_flags.zero_flag = ((acc ^ ram_rdata) == ZERO_BYTE);
      end
      OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
        next_wr    = 1'b1;
        next_wdata = rom_rdata[DATA_W-1:0];
      end
      default: begin
        next_wr = 1'b0;
      end
    endcase
  end

  // Sequencer: take, wait out memory latency, execute, optional dummy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      instr_ready <= 1'b0;
      exec_done   <= 1'b0;
      skip_next   <= 1'b0;
    end else begin
      exec_done <= 1'b0;
      skip_next <= 1'b0;
      case (state)
        ST_IDLE: begin
          instr_ready <= 1'b1;
          if (take) begin
            instr_ready <= 1'b0;
            state       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          exec_done <= 1'b1;
          skip_next <= next_skip;
          if (next_skip) begin
            state <= ST_DUMMY;
          end else begin
            state       <= ST_IDLE;
            instr_ready <= 1'b1;
          end
        end
        ST_DUMMY: begin
          // Dummy cycle stands in for the discarded instruction
          state       <= ST_IDLE;
          instr_ready <= 1'b1;
        end
        default: begin
          state       <= ST_IDLE;
          instr_ready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_q  <= OP_SET_BYTE;
      bit_q <= 3'h0;
    end else if (take) begin
      op_q  <= instr.op;
      bit_q <= instr.bit_sel;
    end
  end

  // Memory port: read at take, write back in the execute cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ram_req <= '0;
    end else begin
      ram_req.rd_en <= take;
      ram_req.wr_en <= exec_fire && next_wr;
      if (take) begin
        ram_req.addr <= instr.addr;
      end
      if (exec_fire) begin
        ram_req.wdata <= next_wdata;
      end
    end
  end

  // ROM port, issued alongside the memory read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rom_rd_en <= 1'b0;
      rom_addr  <= '0;
    end else begin
      rom_rd_en <= take && ((instr.op == OP_TABLE_READ_CURRENT_PAGE) ||
                            (instr.op == OP_TABLE_READ_LAST_PAGE));
      if (take) begin
        if (instr.op == OP_TABLE_READ_LAST_PAGE) begin
          rom_addr <= {LAST_PAGE, table_pointer};
        end else begin
          rom_addr <= {cur_page, table_pointer};
        end
      end
    end
  end

  // Execution wins over a software write landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      acc <= ACC_RST;
    end else if (exec_fire) begin
      acc <= next_acc;
    end else if (apb_wr && (paddr == REG_ACC)) begin
      acc <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags <= STATUS_RST;
    end else if (exec_fire) begin
      flags <= next_flags;
    end else if (apb_wr && (paddr == REG_STATUS)) begin
      flags <= pwdata[STATUS_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      table_pointer <= TABLE_POINTER_RST;
    end else if (apb_wr && (paddr == REG_TABLE_POINTER)) begin
      table_pointer <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      table_high_latch <= TABLE_HIGH_RST;
    end else if (exec_fire && ((op_q == OP_TABLE_READ_CURRENT_PAGE) ||
                               (op_q == OP_TABLE_READ_LAST_PAGE))) begin
      table_high_latch <= rom_rdata[ROM_W-1:DATA_W];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      last_skip <= 1'b0;
    end else if (exec_fire) begin
      last_skip <= next_skip;
    end
  end

  // APB slave: one wait state, so pready is a clean flop output
  always_comb begin
    addr_ok     = 1'b1;
    next_prdata = ZERO_BYTE;
    case (paddr)
      REG_ACC:           next_prdata = acc;
      REG_STATUS:        next_prdata = {2'b00, flags};
      REG_TABLE_POINTER: next_prdata = table_pointer;
      REG_TABLE_HIGH:    next_prdata = table_high_latch;
      REG_STATE:         next_prdata = {6'h00, last_skip, (state != ST_IDLE)};
      default:           addr_ok     = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= {24'h000000, next_prdata};
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule

`default_nettype wire

// [mie_exec_props.sv]
// Checker for the execution subset, bound to every mie_exec.
// Assumes RAM read data one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module mie_exec_props (
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire mie_pkg::mie_instr_type  instr,
  input wire logic                    instr_ready,
  input wire mie_pkg::mie_ram_req_type ram_req,
  input wire logic [7:0]              ram_rdata,
  input wire logic                    rom_rd_en,
  input wire logic [12:0]             rom_addr,
  input wire logic                    exec_done,
  input wire logic                    skip_next,
  input wire logic [7:0]              acc,
  input wire mie_pkg::mie_flags_type  flags
);
  import mie_pkg::*;
  mie_op_type op_q;
  logic [2:0] bit_q;
  logic [7:0] m_q;
  logic       rd_q;
  wire logic  take = instr.valid && instr_ready;
  wire logic  fin  = exec_done;
  always_ff @(posedge sys_clk) begin
    if (take) begin
      op_q  <= instr.op;
      bit_q <= instr.bit_sel;
    end
  end
  // Operand is only valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    rd_q <= ram_req.rd_en;
    if (rd_q) m_q <= ram_rdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_DONE_LATENCY: assert property (take |-> ##3 fin)
    else $error("done pulse not three cycles after take");
  AST_SKIP_DUMMY: assert property (fin && skip_next |-> !instr_ready ##1 instr_ready)
    else $error("no single dummy cycle after skip");
  AST_SET_BYTE: assert property (fin && op_q == OP_SET_BYTE |->
    ram_req.wr_en && ram_req.wdata == ALL_ONES && flags == $past(flags))
    else $error("byte set wrong");
  AST_SET_BIT: assert property (fin && op_q == OP_SET_BIT |->
    ram_req.wr_en && ram_req.wdata == (m_q | (ONE_BYTE << bit_q)))
    else $error("bit set wrong");
  AST_SWAP: assert property (fin && op_q == OP_NIBBLE_EXCHANGE |->
    ram_req.wdata == {m_q[3:0], m_q[7:4]} && flags == $past(flags))
    else $error("nibble exchange wrong");
  AST_INC_MEM: assert property (fin && op_q == OP_INC_MEM_SKIP_ZERO |->
    ram_req.wdata == m_q + ONE_BYTE && skip_next == (m_q == ALL_ONES))
    else $error("increment skip wrong");
  AST_SKIP_BIT_Z: assert property (fin && op_q == OP_SKIP_BIT_ZERO |->
    skip_next == !m_q[bit_q])
    else $error("bit clear skip wrong");
  AST_XOR_TO_MEMORY: assert property (fin && op_q == OP_XOR_TO_MEMORY |-> ram_req.wdata == (acc ^ m_q)
    && flags.zero_flag == (ram_req.wdata == ZERO_BYTE))
    else $error("xor to memory wrong");
  AST_LAST_PAGE: assert property (rom_rd_en && op_q == OP_TABLE_READ_LAST_PAGE |->
    rom_addr[12:8] == LAST_PAGE)
    else $error("last page address wrong");
endmodule
bind mie_exec mie_exec_props mie_exec_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .instr(instr), .instr_ready(instr_ready), .ram_req(ram_req), .ram_rdata(ram_rdata),
  .rom_rd_en(rom_rd_en), .rom_addr(rom_addr), .exec_done(exec_done),
  .skip_next(skip_next), .acc(acc), .flags(flags));
`default_nettype wire

// [mie_exec_bench.sv]
// Self-checking bench: APB master, instruction driver, RAM and ROM models.
// ROM word is {page, pointer ^ 5A} so the page shows up in the high byte.
`timescale 1ns/1ns
`default_nettype none
module mie_exec_bench;
  import mie_pkg::*;
  logic            sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  mie_instr_type   instr = '0;
  logic [4:0]      cur_page = 5'h0B;
  mie_ram_req_type ram_req;
  logic [7:0]      ram_rdata = 8'h00, acc, table_high_latch, paddr = 8'h00;
  logic [15:0]     rom_rdata = 16'h0000;
  logic [12:0]     rom_addr;
  logic            instr_ready, rom_rd_en, exec_done, skip_next, pready, pslverr;
  logic [31:0]     pwdata = 32'h0, prdata;
  mie_flags_type   flags;
  logic [7:0]      mem [256];
  int              num_errors = 0, comparisons = 0;
  mie_exec mie_exec_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr(instr),
    .instr_ready(instr_ready), .cur_page(cur_page), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .rom_rd_en(rom_rd_en), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .exec_done(exec_done),
    .skip_next(skip_next), .acc(acc), .flags(flags), .table_high_latch(table_high_latch),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Synchronous RAM holds its last read word
  always @(posedge sys_clk) begin
    if (ram_req.rd_en) ram_rdata <= mem[ram_req.addr];
    if (ram_req.wr_en) mem[ram_req.addr] <= ram_req.wdata;
    if (rom_rd_en) rom_rdata <= {3'h0, rom_addr[12:8], rom_addr[7:0] ^ 8'h5A};
  end
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One idle cycle after each transfer keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e,
                     input logic err);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (!pready);
    psel <= 0;
    penable <= 0;
    if (!w) chk(prdata, e);
    chk(32'(pslverr), 32'(err));
    @(posedge sys_clk);
  endtask
  task automatic run(input mie_op_type op, input logic [7:0] a, m, input logic [2:0] b,
                     input logic sk);
    mem[a] = m;
    instr <= '{1'b1, op, a, b};
    do @(posedge sys_clk); while (!instr_ready);
    instr.valid <= 0;
    do @(posedge sys_clk); while (!exec_done);
    chk(32'(skip_next), 32'(sk));
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) apb(0, 8'(4 * i), 0, 0, 0);
    apb(1, REG_ACC, 32'h35, 0, 0);
    apb(1, REG_STATUS, 32'h3F, 0, 0);
    apb(1, REG_TABLE_POINTER, 32'h66, 0, 0);
    apb(0, 8'h40, 0, 0, 1);
    apb(0, REG_STATUS, 0, 32'h3F, 0);
    run(OP_SET_BYTE, 8'h10, 8'h12, 0, 0);
    chk(32'(mem[8'h10]), 32'hFF);
    run(OP_SET_BIT, 8'h11, 8'h00, 5, 0);
    chk(32'(mem[8'h11]), 32'h20);
    run(OP_INC_MEM_SKIP_ZERO, 8'h12, 8'hFF, 0, 1);
    chk(32'(mem[8'h12]), 32'h00);
    run(OP_INC_MEM_SKIP_ZERO, 8'h13, 8'h07, 0, 0);
    chk(32'(mem[8'h13]), 32'h08);
    run(OP_INC_TO_ACC_SKIP_ZERO, 8'h14, 8'hFF, 0, 1);
    chk({mem[8'h14], acc}, 16'hFF00);
    run(OP_SKIP_BIT_NONZERO, 8'h15, 8'h08, 3, 1);
    run(OP_SKIP_BIT_NONZERO, 8'h15, 8'h08, 2, 0);
    run(OP_SKIP_BIT_ZERO, 8'h15, 8'h08, 3, 0);
    run(OP_SKIP_BIT_ZERO, 8'h15, 8'h08, 2, 1);
    run(OP_SKIP_IF_ZERO, 8'h15, 8'h00, 0, 1);
    run(OP_SKIP_IF_ZERO, 8'h15, 8'h01, 0, 0);
    run(OP_LOAD_ACC_SKIP_ZERO, 8'h15, 8'h00, 0, 1);
    run(OP_LOAD_ACC_SKIP_ZERO, 8'h15, 8'h80, 0, 0);
    chk(32'(acc), 32'h80);
    run(OP_NIBBLE_EXCHANGE, 8'h16, 8'h3C, 0, 0);
    chk(32'(mem[8'h16]), 32'hC3);
    run(OP_TABLE_READ_CURRENT_PAGE, 8'h17, 8'h00, 0, 0);
    chk({mem[8'h17], table_high_latch}, 16'h3C0B);
    run(OP_TABLE_READ_LAST_PAGE, 8'h18, 8'h00, 0, 0);
    chk({mem[8'h18], table_high_latch}, 16'h3C1F);
    chk(32'(flags), 32'h3F);
    apb(1, REG_STATUS, 32'h00, 0, 0);
    // Signed overflow with no borrow
    run(OP_SUBTRACT_TO_ACC, 8'h19, 8'h01, 0, 0);
    chk({acc, 2'b00, flags}, 16'h7F09);
    run(OP_SUBTRACT_TO_MEMORY, 8'h1A, 8'h7F, 0, 0);
    chk({mem[8'h1A], acc, 2'b00, flags}, 24'h007F07);
    run(OP_XOR_TO_MEMORY, 8'h1B, 8'h70, 0, 0);
    chk({mem[8'h1B], 2'b00, flags}, 16'h0F03);
    run(OP_NIBBLE_EXCHANGE_TO_ACC, 8'h1C, 8'hA5, 0, 0);
    chk({mem[8'h1C], acc, 2'b00, flags}, 24'hA55A03);
    run(OP_XOR_TO_ACC, 8'h1D, 8'h5A, 0, 0);
    chk({acc, 2'b00, flags}, 16'h0007);
    tally_and_finish;
  end
endmodule
`default_nettype wire
